/* pbm_defines.svh */
// constants for the phy basic management register bank
`ifndef PBM_DEFINES_SVH
`define PBM_DEFINES_SVH
`define PBM_IDX_CTRL 5'h00
`define PBM_IDX_STAT 5'h01
`define PBM_IDX_ID_HI 5'h02
`define PBM_IDX_ID_LO 5'h03
`define PBM_IDX_ADV 5'h04
`define PBM_CTRL_RESET 15
`define PBM_CTRL_LOOP 14
`define PBM_CTRL_SPEED 13
`define PBM_CTRL_AN_EN 12
`define PBM_CTRL_PDOWN 11
`define PBM_CTRL_AN_RST 9
`define PBM_CTRL_DUPLEX 8
`define PBM_CTRL_COLTEST 7
`define PBM_STAT_AN_DONE 5
`define PBM_STAT_RFAULT 4
`define PBM_STAT_LINK 2
`define PBM_STAT_JABBER 1
`define PBM_STAT_FIXED 16'h7809
`define PBM_ADV_WR_MASK 16'h2dff
`define PBM_ADV_RESET 16'h0081
`define PBM_ADV_STRAP_MASK 16'h0160
`endif

/* pbm_pkg.sv */
// types shared by the phy basic management register bank
package pbm_pkg;
	// writable control fields, self-clearing bits excluded
	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic an_enable;
		logic power_down;
		logic full_duplex;
		logic col_test;
	} pbm_ctrl_t;
	// strap and conditions arriving from the line side of the phy
	typedef struct packed {
		logic strap_speed;
		logic link_up;
		logic remote_fault;
		logic jabber;
		logic an_done;
		logic an_speed_100;
		logic an_full_duplex;
	} pbm_line_t;
endpackage : pbm_pkg

/* pbm_regs.sv */
// phy basic management registers, indexes 0 to 4, reached by index and data
`include "pbm_defines.svh"

// overview of the bank
// - five sixteen-bit registers, picked by a five-bit index
// - index 0 holds control, index 1 status, 2 and 3 identity, 4 the advertisement
// - other indexes read zero and swallow writes
// - writes land on the edge that samples the strobe
// - reads answer one edge later with a valid pulse
// - a read and a write in one cycle: the read sees the old value
//
// hazards and limits
// - line side levels are asynchronous, so each passes two flops first
// - the strap is synchronised too, so reset must last three edges or more
// - latched status bits hold until a status read, then follow the line
// - an event in the reading cycle wins over the clear, so none is lost
// - a soft reset write drops every other bit of the same word
// - self-clearing bits never read back as one
// - negotiated speed and duplex replace the forced bits while autoneg runs
// - resolved line mode lags its source by one extra cycle
//
// what is not here
// - the autoneg engine itself; only its done flag and result come in
// - partner ability, expansion and vendor registers
// - any buffering beyond the one read data register
//
// every output is a flop or a plain copy of one, so the mac side
// never sees a combinational path from its own strobes
//
module pbm_regs #(
	parameter logic [15:0] OUI_HIGH = 16'h1234, // arbitrary value
	parameter logic [5:0] OUI_LOW = 6'h15, // arbitrary value
	parameter logic [5:0] MODEL_NUM = 6'h0a, // arbitrary value
	parameter logic [3:0] REVISION_NUM = 4'h1 // arbitrary value
) (
	// clock and synchronous reset

	input wire logic MCLK,
	input wire logic RESET_N,

	// index and data access from the mac side

	input wire logic [4:0] REG_INDEX,
	input wire logic REG_WR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	output logic REG_RVALID,

	// strap and line side conditions, all asynchronous

	input wire logic SPEED_SEL,
	input wire logic LINK_UP,
	input wire logic REMOTE_FAULT,
	input wire logic JABBER,
	input wire logic AN_DONE,
	input wire logic AN_SPEED_100,
	input wire logic AN_FULL_DUPLEX,

	// pulses and levels towards the rest of the phy

	output logic PHY_SOFT_RESET,
	output logic AN_RESTART,
	output logic LOOPBACK_EN,
	output logic POWER_DOWN,
	output logic COL_TEST_EN,
	output logic AN_ENABLE,
	output logic LINE_SPEED_100,
	output logic LINE_FULL_DUPLEX,
	output logic [15:0] ADV_WORD
);

	// control defaults; speed and autoneg enable follow the strap level
	function automatic pbm_pkg::pbm_ctrl_t ctrl_default(input logic strap);
		pbm_pkg::pbm_ctrl_t c;
		c = '0;
		c.speed_100 = strap;
		c.an_enable = strap;
		return c;
	endfunction : ctrl_default

	// advertisement defaults; 100 full, 10 full and 10 half follow the strap
	function automatic logic [15:0] adv_default(input logic strap);
		logic [15:0] a;
		a = `PBM_ADV_RESET;
		if (strap) begin
			a = a | `PBM_ADV_STRAP_MASK;
		end
		return a;
	endfunction : adv_default

	// line inputs come from another domain, so two flops before any use
	pbm_pkg::pbm_line_t line_s1_r;
	pbm_pkg::pbm_line_t line_s2_r;

	always_ff @(posedge MCLK) begin
		line_s1_r <= {SPEED_SEL, LINK_UP, REMOTE_FAULT, JABBER, AN_DONE,
			AN_SPEED_100, AN_FULL_DUPLEX};
		line_s2_r <= line_s1_r;
	end

	// writable register contents
	pbm_pkg::pbm_ctrl_t ctrl_r, ctrl_nxt;
	logic [15:0] adv_r, adv_nxt;

	// latched status flags
	logic rfault_l_r, rfault_l_nxt;
	logic jabber_l_r, jabber_l_nxt;
	logic link_l_r, link_l_nxt;

	// one-cycle pulses from self-clearing bits
	logic soft_rst_r, soft_rst_nxt;
	logic an_rst_r, an_rst_nxt;

	// resolved line mode
	logic speed_r, speed_nxt;
	logic duplex_r, duplex_nxt;

	// read answer; data holds until the next read
	logic [15:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;

	// decoded strobes and assembled words
	logic wr_ctrl;
	logic wr_adv;
	logic rd_stat;
	logic soft_req;
	logic an_complete;
	logic [15:0] ctrl_word;
	logic [15:0] stat_word;

	// access decode; the mac side only ever reaches us by index
	assign wr_ctrl = REG_WR && (REG_INDEX == `PBM_IDX_CTRL);
	assign wr_adv = REG_WR && (REG_INDEX == `PBM_IDX_ADV);
	assign rd_stat = REG_RD && (REG_INDEX == `PBM_IDX_STAT);
	assign soft_req = wr_ctrl && REG_WDATA[`PBM_CTRL_RESET];

	// completion only counts while autoneg runs and the phy is powered up
	assign an_complete = line_s2_r.an_done && ctrl_r.an_enable
		&& !ctrl_r.power_down;

	// control word as read back; self-clearing bits always read zero
	always_comb begin
		ctrl_word = '0;
		ctrl_word[`PBM_CTRL_LOOP] = ctrl_r.loopback;
		ctrl_word[`PBM_CTRL_SPEED] = ctrl_r.speed_100;
		ctrl_word[`PBM_CTRL_AN_EN] = ctrl_r.an_enable;
		ctrl_word[`PBM_CTRL_PDOWN] = ctrl_r.power_down;
		ctrl_word[`PBM_CTRL_DUPLEX] = ctrl_r.full_duplex;
		ctrl_word[`PBM_CTRL_COLTEST] = ctrl_r.col_test;
	end

	// status word: fixed abilities plus live and latched flags
	always_comb begin
		stat_word = `PBM_STAT_FIXED;
		stat_word[`PBM_STAT_AN_DONE] = an_complete;
		stat_word[`PBM_STAT_RFAULT] = rfault_l_r;
		stat_word[`PBM_STAT_LINK] = link_l_r;
		stat_word[`PBM_STAT_JABBER] = jabber_l_r;
	end

	// next state of control, advertisement, latches and pulses
	// priority, lowest first:
	// - latches follow their own set and clear terms
	// - a plain write updates control or advertisement
	// - a soft reset write replaces both with strap defaults
	// - the reset input overrides everything
	// keeping all of it in one process makes the priority plain to see
	always_comb begin
		ctrl_nxt = ctrl_r;
		adv_nxt = adv_r;
		soft_rst_nxt = 1'b0;
		an_rst_nxt = 1'b0;
		// latch high: an event in the reading cycle survives the clear
		rfault_l_nxt = line_s2_r.remote_fault | (rfault_l_r & ~rd_stat);
		jabber_l_nxt = line_s2_r.jabber | (jabber_l_r & ~rd_stat);
		// latch low: a read reloads the live level, otherwise a loss sticks
		link_l_nxt = rd_stat ? line_s2_r.link_up
			: (link_l_r & line_s2_r.link_up);
		if (soft_req) begin
			// other bits of a reset write are dropped, defaults win
			ctrl_nxt = ctrl_default(line_s2_r.strap_speed);
			adv_nxt = adv_default(line_s2_r.strap_speed);
			soft_rst_nxt = 1'b1;
			rfault_l_nxt = line_s2_r.remote_fault;
			jabber_l_nxt = line_s2_r.jabber;
			link_l_nxt = line_s2_r.link_up;
		end else begin
			if (wr_ctrl) begin
				ctrl_nxt.loopback = REG_WDATA[`PBM_CTRL_LOOP];
				ctrl_nxt.speed_100 = REG_WDATA[`PBM_CTRL_SPEED];
				ctrl_nxt.an_enable = REG_WDATA[`PBM_CTRL_AN_EN];
				ctrl_nxt.power_down = REG_WDATA[`PBM_CTRL_PDOWN];
				ctrl_nxt.full_duplex = REG_WDATA[`PBM_CTRL_DUPLEX];
				ctrl_nxt.col_test = REG_WDATA[`PBM_CTRL_COLTEST];
				an_rst_nxt = REG_WDATA[`PBM_CTRL_AN_RST];
			end
			if (wr_adv) begin
				// read-only and reserved bits keep their zero
				adv_nxt = (REG_WDATA & `PBM_ADV_WR_MASK)
					| (adv_r & ~`PBM_ADV_WR_MASK);
			end
		end
		if (!RESET_N) begin
			// strap flops run free, so hold reset three edges to catch it
			ctrl_nxt = ctrl_default(line_s2_r.strap_speed);
			adv_nxt = adv_default(line_s2_r.strap_speed);
			soft_rst_nxt = 1'b0;
			an_rst_nxt = 1'b0;
			rfault_l_nxt = 1'b0;
			jabber_l_nxt = 1'b0;
			link_l_nxt = 1'b0;
		end
	end

	// resolved line mode; autoneg result overrides the forced bits
	// the forced bits stay stored while autoneg runs, but the control write
	// that switches autoneg off loads them anew from its own bits 13 and 8
	always_comb begin
		if (ctrl_r.an_enable) begin
			speed_nxt = line_s2_r.an_speed_100;
			duplex_nxt = line_s2_r.an_full_duplex;
		end else begin
			speed_nxt = ctrl_r.speed_100;
			duplex_nxt = ctrl_r.full_duplex;
		end
		if (!RESET_N) begin
			speed_nxt = 1'b0;
			duplex_nxt = 1'b0;
		end
	end

	// read path: one cycle from strobe to data, unknown indexes read zero
	// data is kept when no read is pending, so the mac side may take it late
	// the valid pulse is the only sign of a fresh answer
	always_comb begin
		rdata_nxt = rdata_r;
		rvalid_nxt = REG_RD;
		if (REG_RD) begin
			unique case (REG_INDEX)
				`PBM_IDX_CTRL: rdata_nxt = ctrl_word;
				`PBM_IDX_STAT: rdata_nxt = stat_word;
				`PBM_IDX_ID_HI: rdata_nxt = OUI_HIGH;
				`PBM_IDX_ID_LO: rdata_nxt = {OUI_LOW, MODEL_NUM, REVISION_NUM};
				`PBM_IDX_ADV: rdata_nxt = adv_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
		if (!RESET_N) begin
			rdata_nxt = 16'h0000;
			rvalid_nxt = 1'b0;
		end
	end

	// registers only
	always_ff @(posedge MCLK) begin
		ctrl_r <= ctrl_nxt;
		adv_r <= adv_nxt;
		rfault_l_r <= rfault_l_nxt;
		jabber_l_r <= jabber_l_nxt;
		link_l_r <= link_l_nxt;
		soft_rst_r <= soft_rst_nxt;
		an_rst_r <= an_rst_nxt;
		speed_r <= speed_nxt;
		duplex_r <= duplex_nxt;
		rdata_r <= rdata_nxt;
		rvalid_r <= rvalid_nxt;
	end

	// outputs straight from flops

	// read answer
	assign REG_RDATA = rdata_r;
	assign REG_RVALID = rvalid_r;

	// pulses and levels towards the phy
	assign PHY_SOFT_RESET = soft_rst_r;
	assign AN_RESTART = an_rst_r;
	assign LOOPBACK_EN = ctrl_r.loopback;
	assign POWER_DOWN = ctrl_r.power_down;
	assign COL_TEST_EN = ctrl_r.col_test;
	assign AN_ENABLE = ctrl_r.an_enable;
	assign LINE_SPEED_100 = speed_r;
	assign LINE_FULL_DUPLEX = duplex_r;
	assign ADV_WORD = adv_r;

endmodule : pbm_regs

/* pbm_regs_chk.sv */
// concurrent checks on the ports of the phy basic management register bank
module pbm_regs_chk (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic [4:0] REG_INDEX,
	input wire logic REG_WR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_RD,
	input wire logic [15:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic PHY_SOFT_RESET,
	input wire logic AN_RESTART,
	input wire logic LOOPBACK_EN,
	input wire logic POWER_DOWN,
	input wire logic COL_TEST_EN,
	input wire logic LINE_SPEED_100,
	input wire logic LINE_FULL_DUPLEX,
	input wire logic [15:0] ADV_WORD
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);
	// plain control write; a reset request ignores every other bit
	logic wc;
	assign wc = REG_WR && REG_INDEX == 5'h00 && !REG_WDATA[15];
	AST_RVALID: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered");
	AST_NO_RVALID: assert property (!REG_RD |=> !REG_RVALID)
		else $error("answer without read");
	AST_SOFT_RESET: assert property (REG_WR && REG_INDEX == 5'h00 && REG_WDATA[15] |=>
		PHY_SOFT_RESET ##1 !PHY_SOFT_RESET) else $error("reset pulse wrong");
	AST_AN_RESTART: assert property (wc && REG_WDATA[9] |=> AN_RESTART ##1 !AN_RESTART)
		else $error("restart pulse wrong");
	AST_LOOP: assert property (wc |=> LOOPBACK_EN == $past(REG_WDATA[14]))
		else $error("loopback not taken");
	AST_COLTEST: assert property (wc |=> COL_TEST_EN == $past(REG_WDATA[7]))
		else $error("collision test not taken");
	AST_PDOWN: assert property (wc |=> POWER_DOWN == $past(REG_WDATA[11]))
		else $error("power down not taken");
	AST_FORCED: assert property (wc && !REG_WDATA[12] |=> ##1
		{LINE_SPEED_100, LINE_FULL_DUPLEX} == {$past(REG_WDATA[13], 2), $past(REG_WDATA[8], 2)})
		else $error("forced mode not applied");
	AST_ADV: assert property (REG_WR && REG_INDEX == 5'h04 |=>
		ADV_WORD == ($past(REG_WDATA) & 16'h2dff)) else $error("advert write wrong");
	AST_STATUS: assert property (REG_RD && REG_INDEX == 5'h01 |=>
		REG_RDATA[15:11] == 5'h0f && REG_RDATA[10:6] == 5'h00 && REG_RDATA[3] && REG_RDATA[0])
		else $error("fixed status bits wrong");
endmodule : pbm_regs_chk
bind pbm_regs pbm_regs_chk pbm_regs_chk_i (.MCLK(MCLK), .RESET_N(RESET_N),
	.REG_INDEX(REG_INDEX), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .PHY_SOFT_RESET(PHY_SOFT_RESET),
	.AN_RESTART(AN_RESTART), .LOOPBACK_EN(LOOPBACK_EN), .POWER_DOWN(POWER_DOWN),
	.COL_TEST_EN(COL_TEST_EN), .LINE_SPEED_100(LINE_SPEED_100),
	.LINE_FULL_DUPLEX(LINE_FULL_DUPLEX), .ADV_WORD(ADV_WORD));

/* pbm_mac.sv */
// model of the mac side that reaches the registers by index and data
module pbm_mac (
	input wire logic mclk,
	output logic [4:0] idx,
	output logic wr,
	output logic [15:0] wdata,
	output logic rd,
	input wire logic [15:0] rdata,
	input wire logic rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		idx = 5'h1f;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 16'h0000;
	end
	// released lines carry the inverse so stale values cannot pass for good ones
	task automatic put(input logic [4:0] i, input logic [15:0] d);
		@(negedge mclk);
		idx = i;
		wdata = d;
		wr = 1'b1;
		@(negedge mclk);
		wr = 1'b0;
		wdata = ~d;
		idx = ~i;
	endtask : put
	// answer is looked for under a small bound, ok stays low if none comes
	task automatic get(input logic [4:0] i, output logic [15:0] d, output logic ok);
		@(negedge mclk);
		idx = i;
		rd = 1'b1;
		@(negedge mclk);
		rd = 1'b0;
		idx = ~i;
		ok = 1'b0;
		d = 16'h0000;
		for (int k = 0; k < 4 && !ok; k++) begin
			if (rvalid === 1'b1) begin
				ok = 1'b1;
				d = rdata;
			end else begin
				@(negedge mclk);
			end
		end
	endtask : get
endmodule : pbm_mac

/* pbm_regs_bench.sv */
// self-checking bench for the phy basic management register bank
module pbm_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, reset_n, spd, lnk, rf, jab, an_done, asp, afd;
	logic [4:0] idx;
	logic wr, rd, rvalid, srst, anrst, loop_en, pdown, col_en, an_en, lspd, lfd;
	logic [15:0] wdata, rdata, adv;
	int failures, n_tests;
	// index, write data, value read back afterwards
	logic [4:0] ri [11] = '{5'h00, 5'h00, 5'h00, 5'h04, 5'h04, 5'h04, 5'h04, 5'h02, 5'h03,
		5'h07, 5'h01};
	logic [15:0] rw [11] = '{16'h4580, 16'h2a00, 16'h1000, 16'hffff, 16'h0400, 16'h0800,
		16'h0c00, 16'h0000, 16'hffff, 16'hffff, 16'h0000};
	logic [15:0] rx [11] = '{16'h4180, 16'h2800, 16'h1000, 16'h2dff, 16'h0400, 16'h0800,
		16'h0c00, 16'h1234, 16'h54a1, 16'h0000, 16'h780d};
	pbm_regs pbm_regs_i (.MCLK(mclk), .RESET_N(reset_n), .REG_INDEX(idx), .REG_WR(wr),
		.REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
		.SPEED_SEL(spd), .LINK_UP(lnk), .REMOTE_FAULT(rf), .JABBER(jab), .AN_DONE(an_done),
		.AN_SPEED_100(asp), .AN_FULL_DUPLEX(afd), .PHY_SOFT_RESET(srst), .AN_RESTART(anrst),
		.LOOPBACK_EN(loop_en), .POWER_DOWN(pdown), .COL_TEST_EN(col_en), .AN_ENABLE(an_en),
		.LINE_SPEED_100(lspd), .LINE_FULL_DUPLEX(lfd), .ADV_WORD(adv));
	pbm_mac pbm_mac_i (.mclk(mclk), .idx(idx), .wr(wr), .wdata(wdata), .rd(rd),
		.rdata(rdata), .rvalid(rvalid));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic results;
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// a read that never answers ends the run at once
	task automatic rdc(input logic [4:0] i, input logic [15:0] e);
		logic [15:0] d;
		logic ok;
		pbm_mac_i.get(i, d, ok);
		if (!ok) begin
			failures++;
			results();
		end
		check("rdata", d, e);
	endtask : rdc
	task automatic hard_reset(input logic s);
		reset_n = 1'b0;
		spd = s;
		repeat (16) @(negedge mclk);
		reset_n = 1'b1;
	endtask : hard_reset
	initial begin
		{lnk, rf, jab, an_done, asp, afd} = 6'b100011;
		hard_reset(1'b1);
		rdc(5'h00, 16'h3000);
		rdc(5'h04, 16'h01e1);
		rdc(5'h01, 16'h7809);
		for (int n = 0; n < 11; n++) begin
			pbm_mac_i.put(ri[n], rw[n]);
			rdc(ri[n], rx[n]);
		end
		check("adv word", adv, 16'h0c00);
		// negotiated result must win over the forced bits
		an_done = 1'b1;
		pbm_mac_i.put(5'h00, 16'h3100);
		{asp, afd} = 2'b00;
		repeat (4) @(negedge mclk);
		rdc(5'h01, 16'h782d);
		check("line mode", {14'h0000, lspd, lfd}, 16'h0000);
		check("autoneg enable", {15'h0000, an_en}, 16'h0001);
		pbm_mac_i.put(5'h00, 16'h3900);
		rdc(5'h01, 16'h780d);
		pbm_mac_i.put(5'h00, 16'h2100);
		repeat (2) @(negedge mclk);
		check("line mode", {14'h0000, lspd, lfd}, 16'h0003);
		check("autoneg enable", {15'h0000, an_en}, 16'h0000);
		// short glitches must stay visible until read, then clear
		{lnk, rf, jab} = 3'b011;
		repeat (4) @(negedge mclk);
		{lnk, rf, jab} = 3'b100;
		repeat (4) @(negedge mclk);
		rdc(5'h01, 16'h781b);
		rdc(5'h01, 16'h780d);
		pbm_mac_i.put(5'h00, 16'hc000);
		check("soft reset", {15'h0000, srst}, 16'h0001);
		rdc(5'h00, 16'h3000);
		rdc(5'h04, 16'h01e1);
		check("ctrl outputs", {13'h0000, loop_en, pdown, col_en}, 16'h0000);
		hard_reset(1'b0);
		rdc(5'h00, 16'h0000);
		rdc(5'h04, 16'h0081);
		results();
	end
endmodule : pbm_regs_bench
